// File: verilog/ees_pkg.sv
// Shared constants, state types and reset values for the serial memory slave.
// Assumes one core clock at CLK_HZ and a separate free-running link sampling clock.
`default_nettype none

package ees_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int RESET_PULSE_MS  = 200;
    localparam int PROG_CYCLE_MS   = 10;
    localparam int RESET_PULSE_CYC = (CLK_HZ / 1000) * RESET_PULSE_MS;
    localparam int PROG_CYCLE_CYC  = (CLK_HZ / 1000) * PROG_CYCLE_MS;

    // ------------------------------------------------------------------
    // Bus and array layout
    // ------------------------------------------------------------------
    localparam logic [3:0] DEV_PREFIX = 4'ha;
    localparam int         ADDR_W     = 11;
    localparam int         PAGE_W     = 4;
    localparam int         PAGE_LEN   = 16;
    localparam int         MEM_LEN    = 2048;
    localparam logic [3:0] BIT_LAST   = 4'h8;
    localparam logic [3:0] PAGE_END   = 4'hf;
    localparam int         PFX_MSB    = 7;
    localparam int         PFX_LSB    = 4;
    localparam int         HI_MSB     = 3;
    localparam int         HI_LSB     = 1;
    localparam int         RW_BIT     = 0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_WDATA,
        ST_RDATA,
        ST_COMMIT
    } ees_state_e;

    typedef struct packed {
        logic [2:0]       scl_s;
        logic [2:0]       sda_s;
        logic [2:0]       wp_s;
        logic             scl_f;
        logic             sda_f;
        logic             wp_f;
        logic [1:0]       blk_s;
        logic [1:0]       busy_s;
        ees_state_e       st;
        logic [3:0]       bit_cnt;
        logic             in_ack;
        logic [7:0]       shreg;
        logic [7:0]       txd;
        logic             mack;
        logic [10:0]      addr;
        logic [2:0]       addr_hi;
        logic             wrote;
        logic [15:0][7:0] pbuf;
        logic [15:0]      pmask;
        logic [3:0]       cidx;
        logic             pending;
        logic             prog_tog;
        logic             sda_oe;
    } ees_link_s;

    typedef struct packed {
        logic [2:0]  hi_s;
        logic [2:0]  lo_s;
        logic        hi_f;
        logic        lo_f;
        logic [2:0]  tog_s;
        logic        pulse_on;
        logic [31:0] pulse_cnt;
        logic        prog_busy;
        logic [31:0] prog_cnt;
        logic        blk;
    } ees_core_s;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam ees_link_s LINK_RST = '{
        scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'h1, sda_f: 1'h1,
        st: ST_IDLE, default: '0};

    localparam ees_core_s CORE_RST = '{
        lo_s: 3'h7, lo_f: 1'h1, pulse_on: 1'h1, blk: 1'h1, default: '0};

endpackage

`default_nettype wire

// File: verilog/ees_slave.sv
// Two-wire serial slave in front of a 2048-byte array, with reset supervision.
// Assumes open-drain pins resolved outside; link_clk_i is free running and
// samples the bus much faster than the serial clock; clock_i times the
// millisecond intervals.
`default_nettype none

// Operation
// RL1: START and STOP decoded while clock high
// RL2: Master keeps data stable, ends with STOP
// RL3: Addressing byte accepted only with prefix 1010
// RL4: Three addressing bits give upper address bits
// RL5: Last addressing bit selects read or write
// RL6: Acknowledge matching address, silent otherwise
// RL7: Receiver pulls data low for ninth pulse
// RL8: Write transfers acknowledge every received byte
// RL9: Read sends byte, samples ack, continues or stops
// RL10: Byte write then STOP starts programming
// RL11: No response while programming runs
// RL12: Page write increments only low address bits
// RL13: Page overflow wraps and overwrites buffered bytes
// RL14: Polling acknowledged only after programming ends
// RL15: Write protect refuses first data byte
// RL16: Current read returns last address plus one
// RL17: Address counter wraps from 2047 to zero
// RL18: Random read uses dummy write then read
// RL19: Sequential read increments across whole array
// RL20: Rising edge high pin, falling edge low pin
// RL21: Edge starts 200 ms pulse on reset outputs
// RL22: Memory disabled while any reset pin active
// RL23: Programming cycle lasts at most 10 ms
// RL24: No acknowledge while a reset output active
// RL25: Bus sampled and intervals counted internally
module ees_slave
    import ees_pkg::*;
#(
    parameter int RESET_PULSE_CYCLES = RESET_PULSE_CYC,
    parameter int PROG_CYCLES        = PROG_CYCLE_CYC
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic link_clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    input  wire logic wp_i,
    input  wire logic rst_hi_i,
    output logic      rst_hi_o,
    output logic      rst_hi_oe_o,
    input  wire logic rst_lo_n_i,
    output logic      rst_lo_n_o,
    output logic      rst_lo_n_oe_o
);

    // ------------------------------------------------------------------
    // Shared helpers and storage
    // ------------------------------------------------------------------
    // Glitch filter: a change is taken once second and third stage agree
    function automatic logic filt(input logic [2:0] s, input logic old);
        return (s[1] == s[2]) ? s[2] : old;
    endfunction

    logic [7:0] mem [0:MEM_LEN-1];

    ees_link_s lq;
    ees_link_s ln;
    ees_core_s cq;
    ees_core_s cn;

    logic              scl_rise;
    logic              scl_fall;
    logic              start_c;
    logic              stop_c;
    logic              blocked;
    logic              busy;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0]        mem_rd;
    logic              hi_edge;
    logic              lo_edge;
    logic              prog_req;

    // ------------------------------------------------------------------
    // Link domain: bus engine
    // ------------------------------------------------------------------
    assign mem_rd = mem[lq.addr];
    assign mem_we = (lq.st == ST_COMMIT) && lq.pmask[lq.cidx];
    assign mem_wa = {lq.addr[ADDR_W-1:PAGE_W], lq.cidx};

    always_comb begin
        ln = lq;
        ln.scl_s  = {lq.scl_s[1:0], scl_i};
        ln.sda_s  = {lq.sda_s[1:0], sda_i};
        ln.wp_s   = {lq.wp_s[1:0], wp_i};
        ln.scl_f  = filt(lq.scl_s, lq.scl_f); // RL25
        ln.sda_f  = filt(lq.sda_s, lq.sda_f);
        ln.wp_f   = filt(lq.wp_s, lq.wp_f);
        ln.blk_s  = {lq.blk_s[0], cq.blk};
        ln.busy_s = {lq.busy_s[0], cq.prog_busy};

        scl_rise = ln.scl_f & ~lq.scl_f;
        scl_fall = ~ln.scl_f & lq.scl_f;
        start_c  = lq.scl_f & ln.scl_f & lq.sda_f & ~ln.sda_f; // RL1
        stop_c   = lq.scl_f & ln.scl_f & ~lq.sda_f & ln.sda_f; // RL1
        blocked  = lq.blk_s[1];
        busy     = lq.busy_s[1] | lq.pending;

        // Local busy holds the bus off until the core reports the cycle
        if (lq.pending && lq.busy_s[1]) begin
            ln.pending = 1'b0;
        end

        if (lq.st == ST_COMMIT) begin
            // Page buffer entries marked in pmask go to the array in one pass over all 16
            ln.cidx = lq.cidx + 4'h1; // RL13
            if (lq.cidx == PAGE_END) begin
                ln.st    = ST_IDLE;
                ln.pmask = '0;
            end
        end else if (blocked) begin
            ln.st     = ST_IDLE; // RL22 RL24
            ln.sda_oe = 1'b0;
            ln.wrote  = 1'b0;
            ln.in_ack = 1'b0;
        end else if (start_c) begin
            ln.st      = ST_DEV;
            ln.bit_cnt = '0;
            ln.in_ack  = 1'b0;
            ln.sda_oe  = 1'b0;
            ln.wrote   = 1'b0;
            ln.pmask   = '0;
        end else if (stop_c) begin
            ln.sda_oe = 1'b0;
            ln.in_ack = 1'b0;
            if (lq.wrote) begin
                ln.st       = ST_COMMIT; // RL10
                ln.cidx     = '0;
                ln.pending  = 1'b1;
                ln.prog_tog = ~lq.prog_tog;
                ln.wrote    = 1'b0;
            end else begin
                ln.st = ST_IDLE;
            end
        end else if (lq.st != ST_IDLE) begin
            if (scl_rise) begin
                if (lq.bit_cnt != BIT_LAST) begin
                    ln.shreg   = {lq.shreg[6:0], lq.sda_f};
                    ln.bit_cnt = lq.bit_cnt + 4'h1;
                end else if (lq.in_ack && lq.st == ST_RDATA) begin
                    ln.mack = ~lq.sda_f; // RL9
                end
            end else if (scl_fall) begin
                if (lq.bit_cnt == BIT_LAST && !lq.in_ack) begin
                    ln.in_ack = 1'b1;
                    unique case (lq.st)
                        ST_DEV: begin
                            if (lq.shreg[PFX_MSB:PFX_LSB] == DEV_PREFIX && !busy) begin // RL3 RL11 RL14
                                ln.sda_oe  = 1'b1; // RL6 RL7
                                ln.addr_hi = lq.shreg[HI_MSB:HI_LSB]; // RL4
                                ln.mack    = 1'b1;
                                ln.st      = lq.shreg[RW_BIT] ? ST_RDATA : ST_WORD; // RL5
                            end else begin
                                ln.st = ST_IDLE; // RL6
                            end
                        end
                        ST_WORD: begin
                            ln.sda_oe = 1'b1; // RL8
                            ln.addr   = {lq.addr_hi, lq.shreg}; // RL4 RL18
                            ln.st     = ST_WDATA;
                        end
                        ST_WDATA: begin
                            if (lq.wp_f) begin
                                ln.sda_oe = 1'b0; // RL15
                                ln.wrote  = 1'b0;
                                ln.st     = ST_IDLE;
                            end else begin
                                ln.sda_oe = 1'b1; // RL8
                                ln.pbuf[lq.addr[PAGE_W-1:0]]  = lq.shreg; // RL13
                                ln.pmask[lq.addr[PAGE_W-1:0]] = 1'b1;
                                ln.addr[PAGE_W-1:0] = lq.addr[PAGE_W-1:0] + 4'h1; // RL12
                                ln.wrote = 1'b1;
                            end
                        end
                        ST_RDATA: begin
                            ln.sda_oe = 1'b0; // RL9
                            ln.addr   = lq.addr + 11'h001; // RL17 RL19
                        end
                        default: begin
                            ln.st = ST_IDLE;
                        end
                    endcase
                end else if (lq.in_ack) begin
                    ln.in_ack  = 1'b0;
                    ln.bit_cnt = '0;
                    ln.sda_oe  = 1'b0;
                    if (lq.st == ST_RDATA) begin
                        if (lq.mack) begin
                            ln.txd    = mem_rd; // RL16 RL19
                            ln.sda_oe = ~mem_rd[7];
                            ln.mack   = 1'b0;
                        end else begin
                            ln.st = ST_IDLE; // RL9
                        end
                    end
                end else if (lq.st == ST_RDATA) begin
                    ln.sda_oe = ~lq.txd[3'(4'h7 - lq.bit_cnt)];
                end
            end
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lq <= LINK_RST;
        end else begin
            lq <= ln;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= lq.pbuf[lq.cidx];
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = lq.sda_oe;

    // ------------------------------------------------------------------
    // Core domain: reset supervisor and programming timer
    // ------------------------------------------------------------------
    always_comb begin
        cn = cq;
        cn.hi_s  = {cq.hi_s[1:0], rst_hi_i};
        cn.lo_s  = {cq.lo_s[1:0], rst_lo_n_i};
        cn.hi_f  = filt(cq.hi_s, cq.hi_f);
        cn.lo_f  = filt(cq.lo_s, cq.lo_f);
        cn.tog_s = {cq.tog_s[1:0], lq.prog_tog};

        hi_edge  = cn.hi_f & ~cq.hi_f;
        lo_edge  = ~cn.lo_f & cq.lo_f;
        prog_req = cq.tog_s[1] ^ cq.tog_s[2];

        // Edges seen during the pulse come from our own drive on the pins
        if ((hi_edge || lo_edge) && !cq.pulse_on) begin
            cn.pulse_on  = 1'b1; // RL20
            cn.pulse_cnt = '0;
        end else if (cq.pulse_on) begin
            if (cq.pulse_cnt == 32'(RESET_PULSE_CYCLES - 1)) begin
                cn.pulse_on = 1'b0; // RL21
            end else begin
                cn.pulse_cnt = cq.pulse_cnt + 32'h1;
            end
        end

        if (prog_req) begin
            cn.prog_busy = 1'b1;
            cn.prog_cnt  = '0;
        end else if (cq.prog_busy) begin
            if (cq.prog_cnt == 32'(PROG_CYCLES - 1)) begin
                cn.prog_busy = 1'b0; // RL23
            end else begin
                cn.prog_cnt = cq.prog_cnt + 32'h1;
            end
        end

        cn.blk = cn.pulse_on | cn.hi_f | ~cn.lo_f; // RL22 RL24
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cq <= CORE_RST;
        end else begin
            cq <= cn;
        end
    end

    // Both reset pins are driven active for the whole pulse
    assign rst_hi_o      = 1'b1;
    assign rst_hi_oe_o   = cq.pulse_on; // RL21
    assign rst_lo_n_o    = 1'b0;
    assign rst_lo_n_oe_o = cq.pulse_on; // RL21

endmodule

`default_nettype wire

// File: verif/ees_master_model.sv
// Behavioural two-wire bus master that drives the clock and pulls the data line.
// Assumes a pull-up outside resolves the data line; the clock idles high between frames.
`default_nettype none
module ees_master_model (
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int hp = 200;
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // Data bits move only mid-low, START and STOP mid-high, so the filtered lines never see a change beside a clock edge
    task automatic put(input logic b);
        #(hp / 2) sda_pull_o = !b;
        #(hp / 2) scl_o = 1'b1;
        #(hp) scl_o = 1'b0;
    endtask
    task automatic start();
        #(hp / 2) sda_pull_o = 1'b0;
        #(hp / 2) scl_o = 1'b1;
        #(hp) sda_pull_o = 1'b1;
        #(hp) scl_o = 1'b0;
    endtask
    task automatic stop();
        #(hp / 2) sda_pull_o = 1'b1;
        #(hp / 2) scl_o = 1'b1;
        #(hp) sda_pull_o = 1'b0;
        #(hp);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ak);
        for (int i = 7; i >= 0; i--) put(b[i]);
        #(hp / 2) sda_pull_o = 1'b0;
        #(hp / 2) scl_o = 1'b1;
        #(hp / 2) ak = (sda_i === 1'b0);
        #(hp / 2) scl_o = 1'b0;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] v);
        #(hp / 2) sda_pull_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #(hp / 2) scl_o = 1'b1;
            #(hp / 2) v[i] = (sda_i === 1'b1);
            #(hp / 2) scl_o = 1'b0;
            #(hp / 2);
        end
        put(!mack);
    endtask
endmodule
`default_nettype wire

// File: verif/ees_slave_assertions.sv
// Port checker for the serial memory slave.
// Assumes both clocks run while rst_i is low.
`default_nettype none
module ees_slave_assertions
    import ees_pkg::*;
#(
    parameter int RESET_PULSE_CYCLES = RESET_PULSE_CYC,
    parameter int PROG_CYCLES        = PROG_CYCLE_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic rst_hi_i,
    input wire logic rst_hi_o,
    input wire logic rst_hi_oe_o,
    input wire logic rst_lo_n_i,
    input wire logic rst_lo_n_o,
    input wire logic rst_lo_n_oe_o
);
    logic [31:0] oe_run_ff;
    logic [7:0]  pin_run_ff;
    // Link cycles for which a reset pin has been held active, saturating
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) pin_run_ff <= '0;
        else if (!(rst_hi_i || !rst_lo_n_i)) pin_run_ff <= '0;
        else if (pin_run_ff != 8'hff) pin_run_ff <= pin_run_ff + 8'h1;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) oe_run_ff <= '0;
        else oe_run_ff <= rst_hi_oe_o ? oe_run_ff + 32'h1 : '0;
    end
    chk_oe_equal: assert property (@(posedge clock_i) disable iff (rst_i)
        rst_hi_oe_o == rst_lo_n_oe_o) else $error("reset drives differ");
    chk_pulse_len: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(rst_hi_oe_o) |-> oe_run_ff >= RESET_PULSE_CYCLES)
        else $error("reset pulse short");
    chk_pulse_max: assert property (@(posedge clock_i) disable iff (rst_i)
        oe_run_ff <= RESET_PULSE_CYCLES + 8) else $error("reset pulse long");
    chk_edge_start: assert property (@(posedge clock_i) disable iff (rst_i)
        ($rose(rst_hi_i) || $fell(rst_lo_n_i)) && !rst_hi_oe_o |-> ##[1:6] rst_hi_oe_o)
        else $error("manual reset edge missed");
    chk_pins_fixed: assert property (@(posedge clock_i) disable iff (rst_i)
        !sda_o && rst_hi_o && !rst_lo_n_o) else $error("open drain value wrong");
    chk_ack_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(sda_oe_o) |-> !scl_i) else $error("data pulled while clock high");
    chk_hold_high: assert property (@(posedge link_clk_i) disable iff (rst_i)
        scl_i[*8] ##1 (scl_i && !rst_hi_i && rst_lo_n_i) |-> $stable(sda_oe_o))
        else $error("data moved while clock high");
    chk_pin_block: assert property (@(posedge link_clk_i) disable iff (rst_i)
        pin_run_ff >= 8'd24 |-> !sda_oe_o) else $error("ack under reset pin");
    chk_pulse_block: assert property (@(posedge link_clk_i) disable iff (rst_i)
        rst_hi_oe_o[*6] |-> !$rose(sda_oe_o)) else $error("ack under reset pulse");
endmodule
bind ees_slave ees_slave_assertions #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)) u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .rst_hi_i(rst_hi_i), .rst_hi_o(rst_hi_o), .rst_hi_oe_o(rst_hi_oe_o),
    .rst_lo_n_i(rst_lo_n_i), .rst_lo_n_o(rst_lo_n_o), .rst_lo_n_oe_o(rst_lo_n_oe_o));
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench: master model on the bus, pull resistors resolved here.
// Assumes short pulse and programming counts set through the parameters.
`default_nettype none
`define CHK(g, w) begin compares++; if ((g) !== (w)) begin err_total++; \
    $display("BAD %0t got %h want %h", $time, g, w); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RP = 200;
    logic        clock_i = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_i = 1'b1;
    logic        wp = 1'b0;
    logic        hi_push = 1'b0;
    logic        lo_push = 1'b0;
    logic        scl, m_pull, sda_oe, sda_o, hi_o, hi_oe, lo_o, lo_oe, ack;
    logic [7:0]  d;
    logic [10:0] a;
    logic [31:0] seed = 32'hb20;
    logic [7:0]  mem [2048];
    int          err_total = 0, compares = 0, cyc = 0, t0;
    wire logic   sda = !(m_pull | (sda_oe & !sda_o));
    wire logic   hi_pin = hi_push | (hi_oe & hi_o);
    wire logic   lo_pin = !(lo_push | (lo_oe & !lo_o));
    always #20 clock_i = !clock_i;
    always #7.5 link_clk = !link_clk;
    always @(posedge clock_i) cyc++;
    ees_slave #(.RESET_PULSE_CYCLES(RP), .PROG_CYCLES(400)) uut (.clock_i(clock_i),
        .rst_i(rst_i), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .wp_i(wp), .rst_hi_i(hi_pin), .rst_hi_o(hi_o),
        .rst_hi_oe_o(hi_oe), .rst_lo_n_i(lo_pin), .rst_lo_n_o(lo_o), .rst_lo_n_oe_o(lo_oe));
    ees_master_model m (.sda_i(sda), .scl_o(scl), .sda_pull_o(m_pull));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] dev(input logic [10:0] ad, input logic rd);
        return {4'ha, ad[10:8], rd};
    endfunction
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wait_oe(input logic lvl);
        int n;
        for (n = 0; n < 4 * RP && hi_oe !== lvl; n++) @(posedge clock_i);
        if (n == 4 * RP) begin
            err_total++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    endtask
    task automatic frame(input logic [7:0] b, input logic want);
        m.start();
        m.wbyte(b, ack);
        m.stop();
        `CHK(ack, want)
    endtask
    // Acknowledge polling until the programming cycle ends, bounded
    task automatic poll();
        int n;
        m.start();
        m.wbyte(8'ha0, ack);
        `CHK(ack, 1'b0)
        for (n = 0; n < 6 && !ack; n++) begin
            m.stop();
            m.start();
            m.wbyte(8'ha0, ack);
        end
        `CHK(ack, 1'b1)
        if (!ack) tally_and_finish();
        m.stop();
    endtask
    task automatic wr(input logic [10:0] ad, input int cnt);
        m.start();
        m.wbyte(dev(ad, 1'b0), ack);
        `CHK(ack, 1'b1)
        m.wbyte(ad[7:0], ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < cnt; i++) begin
            d = rnd();
            m.wbyte(d, ack);
            `CHK(ack, !wp)
            if (!wp) mem[{ad[10:4], ad[3:0] + 4'(i)}] = d;
        end
        m.stop();
        if (!wp) poll();
    endtask
    task automatic rd(input logic [10:0] ad, input int cnt, input logic seek);
        if (seek) begin
            m.start();
            m.wbyte(dev(ad, 1'b0), ack);
            m.wbyte(ad[7:0], ack);
        end
        m.start();
        m.wbyte(dev(ad, 1'b1), ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < cnt; i++) begin
            m.rbyte(i < cnt - 1, d);
            `CHK(d, mem[ad + 11'(i)])
        end
        m.stop();
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        @(negedge clock_i) rst_i = 1'b0;
        t0 = cyc;
        wait_oe(1'b0);
        `CHK(cyc - t0 >= RP && cyc - t0 <= RP + 8, 1'b1)
        #1000;
        for (int i = 0; i < 4; i++) frame({4'ha ^ (4'(rnd()) | 4'h1), 4'(rnd())}, 1'b0);
        a = {rnd(), 3'h0} ^ 11'(rnd());
        wr(a, 18);
        rd({a[10:4], 4'h0}, 15, 1'b1);
        rd({a[10:4], 4'hf}, 1, 1'b0);
        m.hp = 500;
        wr(11'h7ff, 1);
        wr(11'h000, 1);
        rd(11'h7ff, 2, 1'b1);
        m.hp = 200;
        @(negedge clock_i) wp = 1'b1;
        wr(11'h000, 1);
        @(negedge clock_i) wp = 1'b0;
        rd(11'h000, 1, 1'b1);
        for (int p = 0; p < 2; p++) begin
            t0 = cyc;
            @(negedge clock_i) {hi_push, lo_push} = p ? 2'b01 : 2'b10;
            wait_oe(1'b1);
            `CHK(cyc - t0 <= 7, 1'b1)
            t0 = cyc;
            frame(8'ha0, 1'b0);
            wait_oe(1'b0);
            `CHK(cyc - t0 >= RP - 1 && cyc - t0 <= RP + 8, 1'b1)
            frame(8'ha0, 1'b0);
            @(negedge clock_i) {hi_push, lo_push} = 2'b00;
            #1000;
            `CHK(hi_oe, 1'b0)
            frame(8'ha0, 1'b1);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
